// ==== logic/nsc_host_ctrl.sv ====
// Host controller issuing status, column change and pull-down feature commands to a NAND die.
`timescale 1ns/1ps
// Functional notes
// - After polling for ready, issue read mode to resume data output.
// - On multi-die targets use enhanced status read, never plain status read.
// - Enhanced status read is command plus three row cycles selecting one die.
// - Enhanced status read enables output; read mode needed before data after reads.
// - Never issue enhanced status read during power-on reset or one-time mode.
// - Random data read is command, two column cycles, confirm, then wait.
// - On multi-die targets issue enhanced status read before random data read.
// - Two-plane random read needs full ready; command, 2 column, 3 row, confirm.
// - Two-plane random read selects which plane's cache register outputs data.
module nsc_host_ctrl
   import nsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic read_enable_n,
   output logic [7:0] nand_io_out,
   output logic nand_io_oe,
   input wire logic [7:0] nand_io_in,
   input wire logic nand_rb
);
   typedef enum logic [2:0] {S_IDLE, S_WLO, S_WHI, S_WAIT, S_RLO, S_RHI, S_RBW} nsc_state_t;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_q1_r, rst_n_r;
   // Two flops so the release never lands near a clock edge.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_q1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_q1_r <= 1'b1;
         rst_n_r <= rst_q1_r;
      end
   end

   nsc_state_t state_r;
   nsc_op_t op_r;
   logic [3:0] cnt_r;
   logic [2:0] idx_r;
   logic [15:0] col_r;
   logic [23:0] row_r;
   logic [1:0] strength_r;
   logic multi_r, sel_r, err_r, wr_pend_r;
   logic [7:0] wr_addr_r, stat_r, data_r;

   // ****************************************
   // Command byte sequences
   // ****************************************
   function automatic logic [7:0] addr_f(input logic [2:0] j, input logic [15:0] c,
                                         input logic [23:0] r);
      logic [7:0] b;
      b = c[7:0];
      unique case (j)
         3'h2: b = c[15:8];
         3'h3: b = r[7:0];
         3'h4: b = r[15:8];
         3'h5: b = r[23:16];
         default: b = c[7:0];
      endcase
      return b;
   endfunction

   // Returns {last, kind, byte} for step i of an operation.
   // No reset or one-time mode entry is ever built, so enhanced status never meets them.
   function automatic logic [10:0] step_f(input nsc_op_t op, input logic [2:0] i);
      logic [7:0] b;
      logic [1:0] k;
      logic l;
      b = CMD_READ_MODE;
      k = K_CMD;
      l = 1'b1;
      unique case (op)
         OP_STATUS, OP_POLL: b = CMD_STATUS;
         OP_STATUS_ENH: begin
            l = (i == 3'h3);
            if (i == 3'h0) b = CMD_STATUS_ENH;
            else begin
               k = K_ADDR;
               b = addr_f(i + 3'h2, col_r, row_r);
            end
         end
         OP_RAND_RD: begin
            l = (i == 3'h3);
            if (i == 3'h0) b = CMD_RAND_RD;
            else if (i == 3'h3) b = CMD_CONFIRM;
            else begin
               k = K_ADDR;
               b = addr_f(i, col_r, row_r);
            end
         end
         OP_RAND_RD2: begin
            l = (i == 3'h6);
            if (i == 3'h0) b = CMD_RAND_RD2;
            else if (i == 3'h6) b = CMD_CONFIRM;
            else begin
               k = K_ADDR;
               b = addr_f(i, col_r, row_r);
            end
         end
         OP_SET_FEAT: begin  // Reserved parameter bits go out as zero.
            l = (i == 3'h5);
            if (i == 3'h0) b = CMD_SET_FEAT;
            else if (i == 3'h1) begin
               k = K_ADDR;
               b = FEAT_RB_STRENGTH;
            end else begin
               k = K_DATA;
               b = (i == 3'h2) ? {6'h00, strength_r} : PARAM_ZERO;
            end
         end
         default: b = CMD_READ_MODE;
      endcase
      return {l, k, b};
   endfunction

   logic [10:0] cur_step;
   assign cur_step = step_f(op_r, idx_r);

   // ****************************************
   // Command acceptance
   // ****************************************
   nsc_op_t req_op;
   logic cmd_wr, refuse, go;
   assign req_op = nsc_op_t'(hwdata[2:0]);
   assign cmd_wr = wr_pend_r && (wr_addr_r == REG_CMD);
   // Orders unsafe for the die or the shared bus are refused and flagged.
   always_comb begin
      refuse = (state_r != S_IDLE);
      // Polling sends a plain status byte too, so it is barred on several dies as well.
      if ((req_op == OP_STATUS || req_op == OP_POLL) && multi_r) refuse = 1'b1;
      if (req_op == OP_RAND_RD && !nand_rb) refuse = 1'b1;
      if (req_op == OP_RAND_RD && multi_r && !sel_r) refuse = 1'b1;
      if (req_op == OP_RAND_RD2 && !(nand_rb && stat_r[SB_ARRAY_READY])) refuse = 1'b1;
   end
   assign go = cmd_wr && !refuse;

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   // Zero wait states: read data is prepared during the address phase.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         wr_pend_r <= hsel && htrans[1] && hready && hwrite;
         wr_addr_r <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
               REG_COL: hrdata <= {16'h0000, col_r};
               REG_ROW: hrdata <= {8'h00, row_r};
               REG_FEAT: hrdata <= {23'h0, multi_r, 6'h00, strength_r};
               REG_STAT: hrdata <= {20'h0, err_r, sel_r, nand_rb,
                                    state_r != S_IDLE, stat_r};
               REG_DATA: hrdata <= {24'h0, data_r};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Address and feature registers; strength resets to full.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         col_r <= 16'h0000;
         row_r <= 24'h00_0000;
         strength_r <= STRENGTH_FULL;
         multi_r <= 1'b0;
      end else if (wr_pend_r) begin
         if (wr_addr_r == REG_COL) col_r <= hwdata[15:0];
         if (wr_addr_r == REG_ROW) row_r <= hwdata[23:0];
         if (wr_addr_r == REG_FEAT) begin
            strength_r <= hwdata[1:0];
            multi_r <= hwdata[FEAT_MULTI_BIT];
         end
      end
   end

   // Refusal flag: a new refusal wins over a clear in the same cycle.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) err_r <= 1'b0;
      else if (cmd_wr && refuse) err_r <= 1'b1;
      else if (wr_pend_r && wr_addr_r == REG_STAT && hwdata[ST_ERR_BIT]) err_r <= 1'b0;
   end

   // ****************************************
   // Pin sequencer
   // ****************************************
   logic status_op;
   assign status_op = (op_r == OP_STATUS) || (op_r == OP_STATUS_ENH) || (op_r == OP_POLL);

   // Walks an operation's bytes, then waits and reads back one byte (a poll rereads until ready); set feature waits out busy instead, read mode just ends.
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= S_IDLE;
         op_r <= OP_READ_MODE;
         cnt_r <= 4'h0;
         idx_r <= 3'h0;
         nand_ce_n <= 1'b1;
         nand_cle <= 1'b0;
         nand_ale <= 1'b0;
         nand_we_n <= 1'b1;
         read_enable_n <= 1'b1;
         nand_io_out <= 8'h00;
         nand_io_oe <= 1'b0;
         stat_r <= 8'h00;
         data_r <= 8'h00;
         sel_r <= 1'b0;
      end else begin
         if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
         unique case (state_r)
            S_IDLE: begin
               nand_io_oe <= 1'b0;
               if (go) begin
                  op_r <= req_op;
                  idx_r <= 3'h0;
                  nand_ce_n <= 1'b0;
                  cnt_r <= WHR_CYC - 4'h1;
                  state_r <= (req_op == OP_DATA) ? S_WAIT : S_WLO;
               end else nand_ce_n <= 1'b1;
            end
            S_WLO: begin
               if (nand_we_n) begin
                  nand_cle <= (cur_step[9:8] == K_CMD);
                  nand_ale <= (cur_step[9:8] == K_ADDR);
                  nand_io_out <= cur_step[7:0];
                  nand_io_oe <= 1'b1;
                  nand_we_n <= 1'b0;
                  cnt_r <= WP_CYC - 4'h1;
               end else if (cnt_r == 4'h0) begin
                  nand_we_n <= 1'b1;
                  cnt_r <= WH_CYC - 4'h1;
                  state_r <= S_WHI;
               end
            end
            S_WHI: if (cnt_r == 4'h0) begin
               nand_cle <= 1'b0;
               nand_ale <= 1'b0;
               idx_r <= idx_r + 3'h1;
               state_r <= S_WLO;
               if (cur_step[10]) begin
                  nand_io_oe <= 1'b0;
                  idx_r <= 3'h0;
                  if (op_r == OP_STATUS_ENH || op_r == OP_RAND_RD2) sel_r <= 1'b1;
                  cnt_r <= (op_r == OP_SET_FEAT) ? WB_CYC - 4'h1 : WHR_CYC - 4'h1;
                  state_r <= (op_r == OP_SET_FEAT) ? S_RBW :
                             (op_r == OP_READ_MODE) ? S_IDLE : S_WAIT;
               end
            end
            S_WAIT: if (cnt_r == 4'h0) begin  // Wait out the turnaround.
               read_enable_n <= 1'b0;
               cnt_r <= RP_CYC - 4'h1;
               state_r <= S_RLO;
            end
            S_RLO: if (cnt_r == 4'h0) begin
               data_r <= nand_io_in;
               if (status_op) stat_r <= nand_io_in;
               read_enable_n <= 1'b1;
               cnt_r <= REH_CYC - 4'h1;
               state_r <= S_RHI;
            end
            S_RHI: if (cnt_r == 4'h0) begin
               if (op_r == OP_POLL && !data_r[SB_RDY]) begin
                  read_enable_n <= 1'b0;
                  cnt_r <= RP_CYC - 4'h1;
                  state_r <= S_RLO;
               end else if (op_r == OP_POLL) begin  // Restore data output.
                  op_r <= OP_READ_MODE;
                  state_r <= S_WLO;
               end else state_r <= S_IDLE;
            end
            S_RBW: if (cnt_r == 4'h0 && nand_rb) state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_we_needs_ce;
      @(posedge clk) disable iff (!rst_n_r) !nand_we_n |-> !nand_ce_n;
   endproperty
   a_we_needs_ce: assert property (p_we_needs_ce) else $error("write strobe without chip enable");

   property p_cle_ale;
      @(posedge clk) disable iff (!rst_n_r) !(nand_cle && nand_ale);
   endproperty
   a_cle_ale: assert property (p_cle_ale) else $error("command and address latch both high");

   property p_no_contention;
      @(posedge clk) disable iff (!rst_n_r) !read_enable_n |-> !nand_io_oe;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("driving data during read");

   property p_param_zero;  // Reserved feature bits must leave as zero.
      @(posedge clk) disable iff (!rst_n_r)
         (!nand_we_n && !nand_cle && !nand_ale && op_r == OP_SET_FEAT) |-> nand_io_out[7:2] == 6'h0;
   endproperty
   a_param_zero: assert property (p_param_zero) else $error("nonzero reserved parameter");

   sequence s_confirm_end;
      $rose(nand_we_n) && nand_cle && nand_io_out == CMD_CONFIRM;
   endsequence
   property p_whr;
      @(posedge clk) disable iff (!rst_n_r) s_confirm_end |-> read_enable_n [*3];
   endproperty
   a_whr: assert property (p_whr) else $error("read requested before turnaround");

   property p_multi_status;
      @(posedge clk) disable iff (!rst_n_r)
         (!nand_we_n && nand_cle && nand_io_out == CMD_STATUS) |-> !multi_r;
   endproperty
   a_multi_status: assert property (p_multi_status) else $error("plain status on multi-die");

   property p_refuse_flag;
      @(posedge clk) disable iff (!rst_n_r) (cmd_wr && refuse) |=> err_r && $stable(op_r);
   endproperty
   a_refuse_flag: assert property (p_refuse_flag) else $error("refused command not flagged");

   property p_poll_ends_read_mode;
      @(posedge clk) disable iff (!rst_n_r)
         (state_r == S_RHI && cnt_r == 4'h0 && op_r == OP_POLL && data_r[SB_RDY])
         |=> ##[1:4] (!nand_we_n && nand_cle && nand_io_out == CMD_READ_MODE);
   endproperty
   a_poll_ends_read_mode: assert property (p_poll_ends_read_mode) else $error("no read mode");

   property p_bus_ok;
      @(posedge clk) disable iff (!rst_n_r) $past(rst_n_r) |-> hreadyout && !hresp;
   endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready okay");

endmodule // nsc_host_ctrl

// ==== pkg/nsc_pkg.sv ====
// Package of constants and types for the NAND status and column command host controller.
package nsc_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 20;
   localparam int T_WP_NS = 50;    // Write-enable low time.
   localparam int T_WH_NS = 50;    // Write-enable high time.
   localparam int T_RP_NS = 50;    // Read-enable low time, data sampled at its end.
   localparam int T_REH_NS = 50;   // Read-enable high time.
   localparam int T_WHR_NS = 120;  // Write high to read wait.
   localparam int T_WB_NS = 100;   // Write high to busy before ready is trusted.
   localparam logic [3:0] WP_CYC = 4'((T_WP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WH_CYC = 4'((T_WH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RP_CYC = 4'((T_RP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] REH_CYC = 4'((T_REH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WHR_CYC = 4'((T_WHR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WB_CYC = 4'((T_WB_NS * CLK_MHZ + 999) / 1000);
   // ****************************************
   // Command and feature bytes
   // ****************************************
   localparam logic [7:0] CMD_READ_MODE = 8'h00;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] CMD_RAND_RD = 8'h05;
   localparam logic [7:0] CMD_RAND_RD2 = 8'h06;
   localparam logic [7:0] CMD_CONFIRM = 8'he0;
   localparam logic [7:0] CMD_SET_FEAT = 8'hef;
   localparam logic [7:0] FEAT_RB_STRENGTH = 8'h81;
   localparam logic [7:0] PARAM_ZERO = 8'h00;
   localparam logic [1:0] STRENGTH_FULL = 2'h0;
   // ****************************************
   // Status bits of the die
   // ****************************************
   localparam int SB_WP = 7;
   localparam int SB_RDY = 6;
   localparam int SB_ARRAY_READY = 5;
   // ****************************************
   // Controller registers
   // ****************************************
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_COL = 8'h04;
   localparam logic [7:0] REG_ROW = 8'h08;
   localparam logic [7:0] REG_FEAT = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_DATA = 8'h14;
   localparam int FEAT_MULTI_BIT = 8;
   localparam int ST_BUSY_BIT = 8;
   localparam int ST_RB_BIT = 9;
   localparam int ST_SEL_BIT = 10;
   localparam int ST_ERR_BIT = 11;
   // Operations written to the command register.
   typedef enum logic [2:0] {
      OP_STATUS, OP_STATUS_ENH, OP_READ_MODE, OP_RAND_RD,
      OP_RAND_RD2, OP_SET_FEAT, OP_DATA, OP_POLL
   } nsc_op_t;
   localparam logic [1:0] K_CMD = 2'h0;
   localparam logic [1:0] K_ADDR = 2'h1;
   localparam logic [1:0] K_DATA = 2'h2;
endpackage

// ==== tb/nsc_nand_model.sv ====
// Behavioural NAND die answering status, column change and pull-down feature commands.
`timescale 1ns/1ps
module nsc_nand_model
   import nsc_pkg::*;
#(
   parameter int BUSY_NS = 500
)
(
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic [7:0] io_in,
   input wire logic [7:0] sr_in,
   output logic [7:0] io_out,
   output logic rb
);
   logic [7:0] op_r = 8'h00;
   logic [7:0] cmd_r = 8'h00;
   logic [7:0] last_r = 8'h00;
   logic [7:0] ab [0:7];
   logic [15:0] col_r = 16'h0000;
   logic [23:0] row_r = 24'h000000;
   logic [2:0] nadr = 3'h0;
   logic [1:0] strength_r = STRENGTH_FULL;
   logic stat_mode = 1'b0;
   logic feat_busy = 1'b0;
   logic [7:0] sr, val;
   int viol = 0;
   realtime t_we = 0;
   event busy_ev;
   // ****************************************
   // Status and output path
   // ****************************************
   // One die, so its status is its own; both ready bits cover every plane.
   always_comb begin
      sr = {sr_in[7], sr_in[6] & !feat_busy, sr_in[5] & !feat_busy, 3'h0, sr_in[1:0]};
      val = stat_mode ? sr : (col_r[7:0] ^ {row_r[6], 7'h00});
   end
   // Released lines show the inverse of the last byte so stale data never looks valid.
   assign io_out = (!ce_n && !re_n) ? val : ~last_r;
   assign rb = sr[6];
   // Each latched byte is a command, an address or a feature parameter.
   always @(posedge we_n) begin
      if (!ce_n) begin
         t_we = $realtime;
         if (cle) begin
            cmd_r = io_in;
            nadr = 3'h0;
            if (io_in != CMD_CONFIRM) begin
               op_r = io_in;
            end
            case (io_in)
               CMD_STATUS: stat_mode = 1'b1;
               CMD_READ_MODE: stat_mode = 1'b0;
               CMD_RAND_RD: if (!sr[6]) viol++;
               CMD_RAND_RD2: if (!(sr[6] && sr[5])) viol++;
               CMD_CONFIRM: begin
                  stat_mode = 1'b0;
                  col_r = {ab[1], ab[0]};
                  if (op_r == CMD_RAND_RD2) row_r = {ab[4], ab[3], ab[2]};
               end
               default: ;
            endcase
         end else begin
            ab[nadr] = io_in;
            nadr = nadr + 3'h1;
            if (op_r == CMD_STATUS_ENH && nadr == 3'h3) begin
               row_r = {ab[2], ab[1], ab[0]};
               stat_mode = 1'b1;
            end
            if (op_r == CMD_SET_FEAT && nadr == 3'h5) begin
               if (ab[0] != FEAT_RB_STRENGTH || ab[1][7:2] != 0) viol++;
               if ({ab[2], ab[3], ab[4]} != 0) viol++;
               strength_r = ab[1][1:0];
               -> busy_ev;
            end
         end
      end
   end
   // A feature write keeps the die busy for a while.
   always begin
      @(busy_ev);
      feat_busy = 1'b1;
      #(BUSY_NS);
      feat_busy = 1'b0;
   end
   // Data reads too soon after a write are a timing fault of the host.
   always @(negedge re_n) begin
      if (!ce_n && ($realtime - t_we) < T_WHR_NS) viol++;
   end
   // Data output walks the column; status output does not.
   always @(posedge re_n) begin
      if (!ce_n) begin
         last_r = val;
         if (!stat_mode) col_r = col_r + 16'h1;
      end
   end
endmodule // nsc_nand_model

// ==== tb/tb_nand_status_column_cmds.sv ====
// Self-checking bench for the NAND status and column command host controller.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_nand_status_column_cmds import nsc_pkg::*;;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, ce_n, cle, ale, we_n, re_n, io_oe, rb;
   logic [7:0] io_out, dev_io, io_in;
   logic [7:0] sr = 8'he0;
   logic [7:0] pat [0:3] = '{8'he0, 8'h03, 8'hc2, 8'h41};
   logic [15:0] cols [0:1] = '{16'h0123, 16'h10ff};
   int err_total = 0;
   int compares = 0;
   // ****************************************
   // Clock, bench and die model
   // ****************************************
   always #25 clk = ~clk;
   // The controller's own byte wins while it drives; otherwise the die's lines.
   assign io_in = io_oe ? io_out : dev_io;
   nsc_host_ctrl u_nsc_host_ctrl (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nand_ce_n(ce_n),
      .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .read_enable_n(re_n),
      .nand_io_out(io_out), .nand_io_oe(io_oe), .nand_io_in(io_in), .nand_rb(rb));
   nsc_nand_model u_nsc_nand_model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .re_n(re_n), .io_in(io_out), .sr_in(sr), .io_out(dev_io), .rb(rb));
   // One single-word transfer; waits on ready in both phases, takes read data at the end.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   // Polls the status word until the sequencer is idle; rd then holds it.
   task automatic wait_idle();
      for (int i = 0; i < 400; i++) begin
         ahb(1'b0, REG_STAT, 32'h0);
         if (rd[ST_BUSY_BIT] === 1'b0) break;
      end
      // A sequencer that never goes idle counts as a mismatch.
      `CHK("idle wait", 1'b0, rd[ST_BUSY_BIT])
   endtask
   task automatic op(input nsc_op_t o);
      ahb(1'b1, REG_CMD, {29'h0, o});
      wait_idle();
   endtask
   task automatic clear_err();
      ahb(1'b1, REG_STAT, 32'h800);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // The tests need a few hundred cycles; this allows sixty thousand.
   initial begin
      #3000000;
      err_total++;
      complete_run();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   // No power-on reset or one-time mode command is ever sent to the die.
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("hreadyout", 1'b1, hreadyout)
      `CHK("hresp", 1'b0, hresp)
      ahb(1'b0, REG_FEAT, 32'h0);
      `CHK("feature reset", 32'h0, rd)
      ahb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      // Status patterns, including a busy die.
      foreach (pat[i]) begin
         sr <= pat[i];
         op(OP_STATUS);
         `CHK("status", {pat[i][7:5], 3'h0, pat[i][1:0]}, rd[7:0])
         `CHK("rb bit", pat[i][6], rd[ST_RB_BIT])
      end
      sr <= 8'he0;
      ahb(1'b1, REG_ROW, 32'h004321c5);
      op(OP_STATUS_ENH);
      `CHK("enhanced status", 8'he0, rd[7:0])
      `CHK("die selected", 1'b1, rd[ST_SEL_BIT])
      `CHK("row cycles", 24'h4321c5, u_nsc_nand_model.row_r)
      op(OP_READ_MODE);
      op(OP_DATA);
      ahb(1'b0, REG_DATA, 32'h0);
      `CHK("read mode data", 8'h80, rd[7:0])
      foreach (cols[i]) begin
         ahb(1'b1, REG_COL, {16'h0, cols[i]});
         op(OP_RAND_RD);
         ahb(1'b0, REG_DATA, 32'h0);
         `CHK("column byte", cols[i][7:0] ^ 8'h80, rd[7:0])
         `CHK("column", cols[i] + 16'h1, u_nsc_nand_model.col_r)
      end
      // Refusals and the cache-read exception.
      sr <= 8'ha0;
      op(OP_RAND_RD);
      `CHK("refused busy", 1'b1, rd[ST_ERR_BIT])
      clear_err();
      sr <= 8'hc0;
      op(OP_RAND_RD);
      `CHK("cache read accept", 1'b0, rd[ST_ERR_BIT])
      op(OP_STATUS);
      op(OP_RAND_RD2);
      `CHK("two-plane busy", 1'b1, rd[ST_ERR_BIT])
      clear_err();
      sr <= 8'he0;
      op(OP_STATUS);
      for (int p = 0; p < 2; p++) begin
         ahb(1'b1, REG_ROW, (p == 0) ? 32'h5 : 32'h45);
         op(OP_RAND_RD2);
         ahb(1'b0, REG_DATA, 32'h0);
         `CHK("plane data", (p == 0) ? 8'hff : 8'h7f, rd[7:0])
      end
      // Several dies: plain status is refused, random read after selection is not.
      ahb(1'b1, REG_FEAT, 32'h100);
      op(OP_STATUS);
      `CHK("multi plain", 1'b1, rd[ST_ERR_BIT])
      clear_err();
      op(OP_POLL);
      `CHK("multi poll", 1'b1, rd[ST_ERR_BIT])
      clear_err();
      op(OP_RAND_RD);
      `CHK("multi random", 1'b0, rd[ST_ERR_BIT])
      for (int s = 3; s >= 0; s--) begin
         ahb(1'b1, REG_FEAT, s);
         op(OP_SET_FEAT);
         `CHK("strength", 2'(s), u_nsc_nand_model.strength_r)
      end
      // Poll a busy die that becomes ready part way through.
      sr <= 8'h80;
      ahb(1'b1, REG_CMD, {29'h0, OP_POLL});
      repeat (40) @(posedge clk);
      sr <= 8'he0;
      wait_idle();
      `CHK("poll ready", 1'b1, rd[SB_RDY])
      `CHK("poll ends", CMD_READ_MODE, u_nsc_nand_model.cmd_r)
      `CHK("bus rules", 0, u_nsc_nand_model.viol)
      complete_run();
   end
endmodule // tb_nand_status_column_cmds
